/* src/icrb_pkg.sv */
// Shared constants, register map and decode helpers of the interrupt control register bank
package icrb_pkg;

    localparam int ADDR_W = 24;
    localparam int DEC_W  = 16;
    localparam int REG_W  = 8;
    localparam int IRQ_N  = 6;

    // Register locations, compared against the low address bits only
    localparam logic [DEC_W-1:0] OFS_SYSTEM_CONTROL   = 16'hFFF2;
    localparam logic [DEC_W-1:0] OFS_SENSE_SELECT     = 16'hFFF4;
    localparam logic [DEC_W-1:0] OFS_REQUEST_ENABLE   = 16'hFFF5;
    localparam logic [DEC_W-1:0] OFS_REQUEST_FLAGS    = 16'hFFF6;
    localparam logic [DEC_W-1:0] OFS_FLAG_CLEAR       = 16'hFFF7;
    localparam logic [DEC_W-1:0] OFS_PRIORITY_SELECT_A = 16'hFFF8;
    localparam logic [DEC_W-1:0] OFS_PRIORITY_SELECT_B = 16'hFFF9;

    // Values after reset and in hardware standby
    localparam logic [REG_W-1:0] RST_SYSTEM_CONTROL = 8'h0B;
    localparam logic [IRQ_N-1:0] RST_IRQ_FIELD      = 6'h00;
    localparam logic [REG_W-1:0] RST_PRIORITY       = 8'h00;
    localparam logic [REG_W-1:0] RDATA_IDLE         = 8'h00;

    // Field positions in system control
    localparam int USER_BIT_ENABLE_POS         = 3;
    localparam int NONMASKABLE_EDGE_SELECT_POS = 2;

    // Priority bit in priority_select_a serving each request line
    localparam logic [2:0] PRIORITY_BIT_OF_LINE [0:IRQ_N-1] =
        '{3'h7, 3'h6, 3'h5, 3'h5, 3'h4, 3'h4};

    // Sampling cycles before pin history is trusted after reset
    localparam logic [1:0] PRIME_DONE = 2'h3;

    function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                     input logic [DEC_W-1:0]  ofs);
        return addr[DEC_W-1:0] == ofs;
    endfunction

    function automatic logic [REG_W-1:0] pad_irq(input logic [IRQ_N-1:0] v);
        return {{(REG_W-IRQ_N){1'b0}}, v};
    endfunction

endpackage

/* src/icrb_sense_if.sv */
// Link between the register bank and the request pin detector
`timescale 1ns/1ps
`default_nettype none
interface icrb_sense_if import icrb_pkg::*; ();
    logic [IRQ_N-1:0] sense_sel;
    logic             nmi_rise_sel;
    logic [IRQ_N-1:0] irq_event;
    logic             nmi_event;

    modport ctl (output sense_sel, output nmi_rise_sel, input irq_event, input nmi_event);
    modport det (input sense_sel, input nmi_rise_sel, output irq_event, output nmi_event);
endinterface
`default_nettype wire

/* src/icrb_irq_sense.sv */
// Pin synchroniser and edge or level detector for the request lines
`timescale 1ns/1ps
`default_nettype none
module icrb_irq_sense
    import icrb_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [IRQ_N-1:0] irq_pin_n,
    input  wire logic             nmi_pin,
    icrb_sense_if.det             d
);

    logic [IRQ_N-1:0] irq_s1;
    logic [IRQ_N-1:0] irq_s2;
    logic [IRQ_N-1:0] irq_s3;
    logic             nmi_s1;
    logic             nmi_s2;
    logic             nmi_s3;
    logic [1:0]       prime;
    logic [IRQ_N-1:0] irq_ev;
    logic             nmi_ev;
    logic [1:0]       next_prime;
    logic [IRQ_N-1:0] next_irq_ev;
    logic             next_nmi_ev;
    logic             primed;

    // Events wait until the history flops hold real pin samples
    always_comb begin
        primed     = (prime == PRIME_DONE);
        next_prime = primed ? prime : prime + 2'h1;
        for (int i = 0; i < IRQ_N; i++) begin
            if (d.sense_sel[i]) begin
                next_irq_ev[i] = primed && irq_s3[i] && !irq_s2[i];
            end else begin
                next_irq_ev[i] = primed && !irq_s2[i];
            end
        end
        if (d.nmi_rise_sel) begin
            next_nmi_ev = primed && nmi_s2 && !nmi_s3;
        end else begin
            next_nmi_ev = primed && !nmi_s2 && nmi_s3;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            irq_s1 <= '1;
            irq_s2 <= '1;
            irq_s3 <= '1;
            nmi_s1 <= 1'b0;
            nmi_s2 <= 1'b0;
            nmi_s3 <= 1'b0;
            prime  <= 2'h0;
            irq_ev <= '0;
            nmi_ev <= 1'b0;
        end else begin
            irq_s1 <= irq_pin_n;
            irq_s2 <= irq_s1;
            irq_s3 <= irq_s2;
            nmi_s1 <= nmi_pin;
            nmi_s2 <= nmi_s1;
            nmi_s3 <= nmi_s2;
            prime  <= next_prime;
            irq_ev <= next_irq_ev;
            nmi_ev <= next_nmi_ev;
        end
    end

    assign d.irq_event = irq_ev;
    assign d.nmi_event = nmi_ev;

    nmi_edge_dir_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        nmi_ev |-> ($past(nmi_s2) == $past(d.nmi_rise_sel)) && ($past(nmi_s3) != $past(nmi_s2)))
        else $error("nonmaskable event on the wrong edge");

    irq_level_sense_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        primed |=> ((irq_ev & ~$past(d.sense_sel)) == (~$past(irq_s2) & ~$past(d.sense_sel))))
        else $error("level-sensed line does not follow the pin");

    irq_edge_sense_a: assert property (
        @(posedge clk) disable iff (!rst_n)
        1'b1 |=> ((irq_ev & $past(d.sense_sel)) & ~($past(irq_s3) & ~$past(irq_s2))) == '0)
        else $error("edge-sensed line fired without a falling edge");

endmodule
`default_nettype wire

/* src/icrb_register_bank.sv */
// Interrupt control register bank: map, request flags, priorities and trap mask control
//
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module icrb_register_bank
    import icrb_pkg::*;
(
    input  wire logic              SYS_CLK,
    input  wire logic              RESET_N,
    input  wire logic              HW_STANDBY,
    input  wire logic              NMI_PIN,
    input  wire logic [IRQ_N-1:0]  IRQ_PIN_N,
    input  wire logic              TRAP_ENTRY,
    input  wire logic [ADDR_W-1:0] REG_ADDR,
    input  wire logic [REG_W-1:0]  REG_WDATA,
    input  wire logic              REG_WR,
    input  wire logic              REG_RD,
    output var  logic [REG_W-1:0]  REG_RDATA,
    output var  logic              INT_REQ,
    output var  logic [IRQ_N-1:0]  IRQ_PENDING,
    output var  logic [IRQ_N-1:0]  IRQ_LEVEL,
    output var  logic              NMI_REQ,
    output var  logic              AUX_BIT_IS_MASK,
    output var  logic [REG_W-1:0]  PRIO_A,
    output var  logic [REG_W-1:0]  PRIO_B,
    output var  logic              GLOBAL_MASK_SET,
    output var  logic              AUX_MASK_SET
);

    icrb_sense_if sif ();

    icrb_irq_sense u_sense (
        .clk       (SYS_CLK),
        .rst_n     (RESET_N),
        .irq_pin_n (IRQ_PIN_N),
        .nmi_pin   (NMI_PIN),
        .d         (sif)
    );

    // Standby pin synchroniser
    logic stby_s1;
    logic stby_s2;
    logic next_stby_s1;
    logic next_stby_s2;

    always_comb begin
        next_stby_s1 = HW_STANDBY;
        next_stby_s2 = stby_s1;
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stby_s1 <= 1'b0;
            stby_s2 <= 1'b0;
        end else begin
            stby_s1 <= next_stby_s1;
            stby_s2 <= next_stby_s2;
        end
    end

    // Register bank state
    logic [REG_W-1:0] system_control;
    logic [IRQ_N-1:0] request_sense_select;
    logic [IRQ_N-1:0] request_enable;
    logic [IRQ_N-1:0] request_flags;
    logic [REG_W-1:0] priority_select_a;
    logic [REG_W-1:0] priority_select_b;

    logic [REG_W-1:0] next_system_control;
    logic [IRQ_N-1:0] next_request_sense_select;
    logic [IRQ_N-1:0] next_request_enable;
    logic [IRQ_N-1:0] next_request_flags;
    logic [REG_W-1:0] next_priority_select_a;
    logic [REG_W-1:0] next_priority_select_b;
    logic [REG_W-1:0] next_rdata;
    logic             next_int_req;
    logic [IRQ_N-1:0] next_irq_pending;
    logic [IRQ_N-1:0] next_irq_level;
    logic             next_nmi_req;
    logic             next_aux_bit_is_mask;
    logic             next_global_mask_set;
    logic             next_aux_mask_set;

    logic [IRQ_N-1:0] flag_clear;
    logic [REG_W-1:0] read_mux;
    logic             addr_mapped;

    always_comb begin
        next_system_control       = system_control;
        next_request_sense_select = request_sense_select;
        next_request_enable       = request_enable;
        next_priority_select_a    = priority_select_a;
        next_priority_select_b    = priority_select_b;
        flag_clear                = '0;

        if (REG_WR) begin
            if (reg_hit(REG_ADDR, OFS_SYSTEM_CONTROL)) begin
                next_system_control = REG_WDATA;
            end
            if (reg_hit(REG_ADDR, OFS_SENSE_SELECT)) begin
                next_request_sense_select = REG_WDATA[IRQ_N-1:0];
            end
            if (reg_hit(REG_ADDR, OFS_REQUEST_ENABLE)) begin
                next_request_enable = REG_WDATA[IRQ_N-1:0];
            end
            if (reg_hit(REG_ADDR, OFS_REQUEST_FLAGS)) begin
                flag_clear = ~REG_WDATA[IRQ_N-1:0];
            end
            if (reg_hit(REG_ADDR, OFS_FLAG_CLEAR)) begin
                flag_clear = REG_WDATA[IRQ_N-1:0];
            end
            if (reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_A)) begin
                next_priority_select_a = REG_WDATA;
            end
            if (reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_B)) begin
                next_priority_select_b = REG_WDATA;
            end
        end

        // A new request beats a clear in the same cycle; ones written never set
        next_request_flags = (request_flags & ~flag_clear) | sif.irq_event;

        // Hardware standby holds the bank at its initial values
        if (stby_s2) begin
            next_system_control       = RST_SYSTEM_CONTROL;
            next_request_sense_select = RST_IRQ_FIELD;
            next_request_enable       = RST_IRQ_FIELD;
            next_request_flags        = RST_IRQ_FIELD;
            next_priority_select_a    = RST_PRIORITY;
            next_priority_select_b    = RST_PRIORITY;
        end

        addr_mapped = reg_hit(REG_ADDR, OFS_SYSTEM_CONTROL)
                   || reg_hit(REG_ADDR, OFS_SENSE_SELECT)
                   || reg_hit(REG_ADDR, OFS_REQUEST_ENABLE)
                   || reg_hit(REG_ADDR, OFS_REQUEST_FLAGS)
                   || reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_A)
                   || reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_B);
        read_mux = RDATA_IDLE;
        if (reg_hit(REG_ADDR, OFS_SYSTEM_CONTROL)) begin
            read_mux = system_control;
        end else if (reg_hit(REG_ADDR, OFS_SENSE_SELECT)) begin
            read_mux = pad_irq(request_sense_select);
        end else if (reg_hit(REG_ADDR, OFS_REQUEST_ENABLE)) begin
            read_mux = pad_irq(request_enable);
        end else if (reg_hit(REG_ADDR, OFS_REQUEST_FLAGS)) begin
            read_mux = pad_irq(request_flags);
        end else if (reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_A)) begin
            read_mux = priority_select_a;
        end else if (reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_B)) begin
            read_mux = priority_select_b;
        end
        next_rdata = REG_RD ? read_mux : RDATA_IDLE;

        next_int_req     = |(request_flags & request_enable);
        next_irq_pending = request_flags & request_enable;
        for (int i = 0; i < IRQ_N; i++) begin
            next_irq_level[i] = priority_select_a[PRIORITY_BIT_OF_LINE[i]];
        end
        // No mask or priority gates the nonmaskable request
        next_nmi_req    = sif.nmi_event;
        next_aux_bit_is_mask = !system_control[USER_BIT_ENABLE_POS];
        next_global_mask_set = TRAP_ENTRY;
        next_aux_mask_set    = TRAP_ENTRY && !system_control[USER_BIT_ENABLE_POS];
    end

    always_ff @(posedge SYS_CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            system_control       <= RST_SYSTEM_CONTROL;
            request_sense_select <= RST_IRQ_FIELD;
            request_enable       <= RST_IRQ_FIELD;
            request_flags        <= RST_IRQ_FIELD;
            priority_select_a    <= RST_PRIORITY;
            priority_select_b    <= RST_PRIORITY;
            REG_RDATA            <= RDATA_IDLE;
            INT_REQ              <= 1'b0;
            IRQ_PENDING          <= '0;
            IRQ_LEVEL            <= '0;
            NMI_REQ              <= 1'b0;
            AUX_BIT_IS_MASK      <= 1'b0;
            PRIO_A               <= RST_PRIORITY;
            PRIO_B               <= RST_PRIORITY;
            GLOBAL_MASK_SET      <= 1'b0;
            AUX_MASK_SET         <= 1'b0;
        end else begin
            system_control       <= next_system_control;
            request_sense_select <= next_request_sense_select;
            request_enable       <= next_request_enable;
            request_flags        <= next_request_flags;
            priority_select_a    <= next_priority_select_a;
            priority_select_b    <= next_priority_select_b;
            REG_RDATA            <= next_rdata;
            INT_REQ              <= next_int_req;
            IRQ_PENDING          <= next_irq_pending;
            IRQ_LEVEL            <= next_irq_level;
            NMI_REQ              <= next_nmi_req;
            AUX_BIT_IS_MASK      <= next_aux_bit_is_mask;
            PRIO_A               <= priority_select_a;
            PRIO_B               <= priority_select_b;
            GLOBAL_MASK_SET      <= next_global_mask_set;
            AUX_MASK_SET         <= next_aux_mask_set;
        end
    end

    // The detector sees the live configuration bits
    assign sif.sense_sel    = request_sense_select;
    assign sif.nmi_rise_sel = system_control[NONMASKABLE_EDGE_SELECT_POS];

    unmapped_read_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_RD && !addr_mapped) |=> (REG_RDATA == RDATA_IDLE))
        else $error("unmapped read returned nonzero data");

    sysctl_read_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_RD && reg_hit(REG_ADDR, OFS_SYSTEM_CONTROL)) |=> (REG_RDATA == $past(system_control)))
        else $error("system control read data wrong");

    flag_no_set_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        1'b1 |=> ((request_flags & ~$past(request_flags) & ~$past(sif.irq_event)) == '0))
        else $error("request flag rose without a request");

    flag_zero_clear_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_WR && reg_hit(REG_ADDR, OFS_REQUEST_FLAGS))
            |=> ((request_flags & ~$past(REG_WDATA[IRQ_N-1:0]) & ~$past(sif.irq_event)) == '0))
        else $error("writing zero did not clear a flag");

    sysctl_standby_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        stby_s2 |=> (system_control == RST_SYSTEM_CONTROL))
        else $error("system control not initialised in standby");

    aux_role_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        1'b1 |=> (AUX_BIT_IS_MASK == !$past(system_control[USER_BIT_ENABLE_POS])))
        else $error("auxiliary bit role does not follow bit 3");

    bank_standby_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        stby_s2 |=> (request_sense_select == RST_IRQ_FIELD) && (request_enable == RST_IRQ_FIELD)
            && (request_flags == RST_IRQ_FIELD) && (priority_select_b == RST_PRIORITY))
        else $error("request registers not cleared in standby");

    prio_write_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_WR && !stby_s2 && reg_hit(REG_ADDR, OFS_PRIORITY_SELECT_B))
            |=> (priority_select_b == $past(REG_WDATA)) ##1 (PRIO_B == $past(REG_WDATA, 2)))
        else $error("priority register write lost");

    prio_a_clear_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        stby_s2 |=> (priority_select_a == RST_PRIORITY))
        else $error("first priority register not cleared");

    line0_level_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        1'b1 |=> (IRQ_LEVEL[0] == $past(priority_select_a[7])) && (IRQ_LEVEL[5] == $past(priority_select_a[4])))
        else $error("line priority level does not follow its bit");

    nmi_accept_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        sif.nmi_event |=> NMI_REQ)
        else $error("nonmaskable request dropped");

    trap_mask_a: assert property (
        @(posedge SYS_CLK) disable iff (!RESET_N)
        TRAP_ENTRY |=> GLOBAL_MASK_SET
            && (AUX_MASK_SET == !$past(system_control[USER_BIT_ENABLE_POS])))
        else $error("trap entry mask setting wrong");

endmodule
`default_nettype wire

/* testbench/icrb_cpu_model.sv */
// Behavioural CPU core model: register bus master and trap pulses
`timescale 1ns/1ps
`default_nettype none
module icrb_cpu_model
    import icrb_pkg::*;
(
    input  wire logic              clk,
    output var  logic [ADDR_W-1:0] reg_addr,
    output var  logic [REG_W-1:0]  reg_wdata,
    output var  logic              reg_wr,
    output var  logic              reg_rd,
    input  wire logic [REG_W-1:0]  reg_rdata,
    output var  logic              trap_entry
);
    initial begin
        reg_addr   = '0;
        reg_wdata  = '0;
        reg_wr     = 1'b0;
        reg_rd     = 1'b0;
        trap_entry = 1'b0;
    end

    // Idle address and data lines show the inverse of their last value and the strobes drop, so a stale bus never looks valid
    task automatic release_bus();
        reg_wr    <= 1'b0;
        reg_rd    <= 1'b0;
        reg_addr  <= ~reg_addr;
        reg_wdata <= ~reg_wdata;
    endtask

    task automatic wr(input logic [ADDR_W-1:0] a, input logic [REG_W-1:0] d);
        @(posedge clk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge clk);
        release_bus();
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [ADDR_W-1:0] a, output logic [REG_W-1:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        release_bus();
        @(negedge clk);
        d = reg_rdata;
    endtask

    // Software clears flags by writing zero to them and one everywhere else
    task automatic clear_flags(input logic [REG_W-1:0] mask);
        wr({8'h00, OFS_REQUEST_FLAGS}, ~mask);
    endtask

    task automatic trap();
        @(posedge clk);
        trap_entry <= 1'b1;
        @(posedge clk);
        trap_entry <= 1'b0;
    endtask
endmodule
`default_nettype wire

/* testbench/icrb_register_bank_tb_top.sv */
// Self-checking testbench of the interrupt control register bank
`timescale 1ns/1ps
`default_nettype none
module icrb_register_bank_tb_top import icrb_pkg::*; ();
    logic              sys_clk, reset_n, hw_standby, nmi_pin, trap_entry, reg_wr, reg_rd;
    logic              int_req, nmi_req, aux_is_mask, glob_mask_set, aux_mask_set;
    logic [IRQ_N-1:0]  irq_pin_n, irq_pending, irq_level;
    logic [ADDR_W-1:0] reg_addr;
    logic [REG_W-1:0]  reg_wdata, reg_rdata, prio_a, prio_b, rdv, pv;
    logic [7:0]        nmi_cnt;
    int                err_total, checked;

    localparam logic [DEC_W-1:0] MAP [0:7] = '{OFS_SYSTEM_CONTROL, OFS_SENSE_SELECT,
        OFS_REQUEST_ENABLE, OFS_REQUEST_FLAGS, OFS_PRIORITY_SELECT_A, OFS_PRIORITY_SELECT_B,
        OFS_FLAG_CLEAR, 16'hFFF3};
    localparam logic [7:0] PVAL [0:1] = '{8'hA5, 8'h5A};
    localparam logic [5:0] PLVL [0:1] = '{6'h0D, 6'h32};
    localparam logic [7:0] NCNT [0:3] = '{8'h01, 8'h01, 8'h01, 8'h02};

    icrb_register_bank icrb_register_bank_inst (
        .SYS_CLK(sys_clk), .RESET_N(reset_n), .HW_STANDBY(hw_standby), .NMI_PIN(nmi_pin),
        .IRQ_PIN_N(irq_pin_n), .TRAP_ENTRY(trap_entry), .REG_ADDR(reg_addr),
        .REG_WDATA(reg_wdata), .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(reg_rdata),
        .INT_REQ(int_req), .IRQ_PENDING(irq_pending), .IRQ_LEVEL(irq_level),
        .NMI_REQ(nmi_req), .AUX_BIT_IS_MASK(aux_is_mask), .PRIO_A(prio_a), .PRIO_B(prio_b),
        .GLOBAL_MASK_SET(glob_mask_set), .AUX_MASK_SET(aux_mask_set));

    icrb_cpu_model icrb_cpu_model_inst (
        .clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trap_entry(trap_entry));

    initial begin
        sys_clk = 1'b0;
        forever #25 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n)
            nmi_cnt <= 8'h00;
        else if (nmi_req === 1'b1)
            nmi_cnt <= nmi_cnt + 8'h01;
    end

    task automatic give_verdict();
        $display("checks made %0d, mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic chk8(input string n, input logic [7:0] e, input logic [7:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk6(input string n, input logic [5:0] e, input logic [5:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk1(input string n, input logic e, input logic g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s expected %b seen %b", n, e, g);
        end
    endtask

    task automatic rchk(input string n, input logic [DEC_W-1:0] ofs, input logic [7:0] e);
        icrb_cpu_model_inst.rd({8'h00, ofs}, rdv);
        chk8(n, e, rdv);
    endtask

    task automatic wreg(input logic [DEC_W-1:0] ofs, input logic [7:0] d);
        icrb_cpu_model_inst.wr({8'h00, ofs}, d);
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    // Unmapped and write-only places read zero as well
    task automatic check_initial();
        for (int i = 0; i < 8; i++)
            rchk("initial", MAP[i], (i == 0) ? 8'h0B : 8'h00);
        chk1("aux mask role", 1'b0, aux_is_mask);
        chk8("prio a", 8'h00, prio_a);
        chk6("level", 6'h00, irq_level);
    endtask

    task automatic trap_chk(input logic aux);
        icrb_cpu_model_inst.trap();
        @(negedge sys_clk);
        chk1("global mask set", 1'b1, glob_mask_set);
        chk1("aux mask set", aux, aux_mask_set);
        @(negedge sys_clk);
        chk1("global mask end", 1'b0, glob_mask_set);
    endtask

    initial begin
        repeat (5000) @(posedge sys_clk);
        err_total++;
        give_verdict();
    end

    initial begin
        reset_n    = 1'b0;
        hw_standby = 1'b0;
        nmi_pin    = 1'b1;
        irq_pin_n  = '1;
        err_total  = 0;
        checked    = 0;
        repeat (5) @(posedge sys_clk);
        reset_n <= 1'b1;
        cyc(5);
        check_initial();
        // Upper address bits must not disturb the decode
        for (int i = 0; i < 2; i++) begin
            pv = PVAL[i];
            icrb_cpu_model_inst.wr({8'h12, OFS_PRIORITY_SELECT_A}, pv);
            wreg(OFS_PRIORITY_SELECT_B, ~pv);
            rchk("prio a rd", OFS_PRIORITY_SELECT_A, pv);
            rchk("prio b rd", OFS_PRIORITY_SELECT_B, ~pv);
            cyc(2);
            chk8("prio b", ~pv, prio_b);
            chk8("prio a", pv, prio_a);
            chk6("level", PLVL[i], irq_level);
        end
        wreg(OFS_SENSE_SELECT, 8'hFF);
        rchk("sense", OFS_SENSE_SELECT, 8'h3F);
        @(posedge sys_clk) irq_pin_n[2] <= 1'b0;
        cyc(3);
        @(posedge sys_clk) irq_pin_n[2] <= 1'b1;
        cyc(6);
        rchk("flags edge", OFS_REQUEST_FLAGS, 8'h04);
        chk1("int masked", 1'b0, int_req);
        wreg(OFS_REQUEST_ENABLE, 8'h04);
        cyc(3);
        chk1("int raised", 1'b1, int_req);
        chk6("pending", 6'h04, irq_pending);
        wreg(OFS_REQUEST_FLAGS, 8'hFF);
        rchk("flags no set", OFS_REQUEST_FLAGS, 8'h04);
        wreg(OFS_FLAG_CLEAR, 8'h04);
        cyc(3);
        chk1("int cleared", 1'b0, int_req);
        // Level sensing re-sets the flag for as long as the line stays low
        wreg(OFS_SENSE_SELECT, 8'h3E);
        @(posedge sys_clk) irq_pin_n[0] <= 1'b0;
        cyc(6);
        icrb_cpu_model_inst.clear_flags(8'h01);
        rchk("flags level", OFS_REQUEST_FLAGS, 8'h01);
        @(posedge sys_clk) irq_pin_n[0] <= 1'b1;
        cyc(6);
        icrb_cpu_model_inst.clear_flags(8'h01);
        rchk("flags zero", OFS_REQUEST_FLAGS, 8'h00);
        for (int i = 0; i < 4; i++) begin
            if (i == 2)
                wreg(OFS_SYSTEM_CONTROL, 8'h0F);
            @(posedge sys_clk) nmi_pin <= i[0];
            cyc(8);
            chk8("nmi count", NCNT[i], nmi_cnt);
        end
        trap_chk(1'b0);
        wreg(OFS_SYSTEM_CONTROL, 8'h03);
        rchk("sysctl", OFS_SYSTEM_CONTROL, 8'h03);
        chk1("aux mask role", 1'b1, aux_is_mask);
        trap_chk(1'b1);
        wreg(OFS_PRIORITY_SELECT_A, 8'hFF);
        wreg(OFS_REQUEST_ENABLE, 8'h3F);
        @(posedge sys_clk) hw_standby <= 1'b1;
        cyc(6);
        @(posedge sys_clk) hw_standby <= 1'b0;
        cyc(4);
        check_initial();
        wreg(OFS_PRIORITY_SELECT_B, 8'h77);
        @(posedge sys_clk) reset_n <= 1'b0;
        cyc(2);
        @(posedge sys_clk) reset_n <= 1'b1;
        cyc(5);
        check_initial();
        give_verdict();
    end
endmodule
`default_nettype wire
